/* File: common/ebr_regs.svh */
`ifndef EBR_REGS_SVH
`define EBR_REGS_SVH

// array geometry: 512 words of up to 36 bits
`define EBR_ADDR_W     9
`define EBR_DATA_W     36

// widths for which read-before-write is offered
`define EBR_RBW_W0     9
`define EBR_RBW_W1     18
`define EBR_RBW_W2     36

// port indices inside the generate loop
`define EBR_PORT_A     0
`define EBR_PORT_B     1
`define EBR_NUM_PORTS  2

// read latency in port clocks, counted from address capture
`define EBR_LAT_BYPASS 1
`define EBR_LAT_REG    2

`endif

/* File: common/ebr_pkg.sv */
`include "ebr_regs.svh"

package ebr_pkg;

   // write behaviour of one port
   typedef enum logic [1:0] {
      wm_normal,
      wm_write_through,
      wm_read_before_write
   } write_mode_e;

   // how the two ports share the array
   typedef enum logic [1:0] {
      pm_single,
      pm_true_dual,
      pm_pseudo_dual
   } port_mode_e;

   typedef logic [`EBR_DATA_W-1:0] word_t;
   typedef logic [`EBR_ADDR_W-1:0] addr_t;

   // one port request as presented by the fabric
   typedef struct packed {
      logic  en;
      logic  we;
      addr_t addr;
      word_t din;
   } port_req_s;

   // static configuration of one port
   typedef struct packed {
      write_mode_e mode;
      logic        out_reg;
   } port_cfg_s;

endpackage

/* File: logic/ram_out_stage.sv */
// output latch plus optional output register of one port
module ram_out_stage
   import ebr_pkg::*;
#(
   parameter bit ASYNC_CLR = 1'b0
) (
   // clock and resets
   input  wire logic  clk_sys,
   input  wire logic  rst_n,
   input  wire logic  global_reset_n,
   input  wire logic  port_reset,
   // configuration
   input  wire logic  out_reg,
   // data from the array
   input  wire logic  load,
   input  wire word_t load_data,
   // to the fabric
   output word_t      dout,
   output logic       dout_vld
);

   word_t latch_q;
   word_t latch_d;
   word_t dout_q;
   word_t dout_d;
   logic  load_q;
   logic  vld_q;
   logic  vld_d;
   logic  clr;

   // local reset clears this port only; chip-wide reset clears both ports
   assign clr     = port_reset | ~global_reset_n;
   assign latch_d = load ? load_data : latch_q;
   // bypass loads the output flop at the same edge as the latch
   assign dout_d  = out_reg ? latch_q : latch_d;
   assign vld_d   = out_reg ? load_q : load;

   generate
      if (ASYNC_CLR) begin : g_async
         // async clear: takes effect without waiting for an edge
         always_ff @(posedge clk_sys or posedge clr) begin
            if (clr) begin
               latch_q <= '0;
               dout_q  <= '0;
               load_q  <= 1'b0;
               vld_q   <= 1'b0;
            end else if (!rst_n) begin
               latch_q <= '0;
               dout_q  <= '0;
               load_q  <= 1'b0;
               vld_q   <= 1'b0;
            end else begin
               latch_q <= latch_d;
               dout_q  <= dout_d;
               load_q  <= load;
               vld_q   <= vld_d;
            end
         end
      end else begin : g_sync
         // sync clear: sampled on the port clock like any input
         always_ff @(posedge clk_sys) begin
            if (clr || !rst_n) begin
               latch_q <= '0;
               dout_q  <= '0;
               load_q  <= 1'b0;
               vld_q   <= 1'b0;
            end else begin
               latch_q <= latch_d;
               dout_q  <= dout_d;
               load_q  <= load;
               vld_q   <= vld_d;
            end
         end
      end
   endgenerate

   assign dout     = dout_q;
   assign dout_vld = vld_q;

endmodule

/* File: logic/embedded_block_ram.sv */
module embedded_block_ram
   import ebr_pkg::*;
#(
   parameter int unsigned DATA_W      = `EBR_DATA_W,
   parameter bit          ASYNC_CLR_A = 1'b0,
   parameter bit          ASYNC_CLR_B = 1'b0
) (
   // clock and resets
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic       global_reset_n,
   // per-port output resets
   input  wire logic       port_a_output_reset,
   input  wire logic       port_b_output_reset,
   // static configuration
   input  wire port_mode_e port_mode,
   input  wire port_cfg_s  cfg_a,
   input  wire port_cfg_s  cfg_b,
   // port a request
   input  wire port_req_s  req_a,
   // port b request
   input  wire port_req_s  req_b,
   // read data towards the fabric
   output word_t           dout_a,
   output logic            dout_vld_a,
   output word_t           dout_b,
   output logic            dout_vld_b
);

   localparam int unsigned DEPTH = 1 << `EBR_ADDR_W;
   localparam int unsigned NP    = `EBR_NUM_PORTS;

   // read-before-write exists only at the three wide widths
   localparam bit RBW_OK = (DATA_W == `EBR_RBW_W0) ||
                           (DATA_W == `EBR_RBW_W1) ||
                           (DATA_W == `EBR_RBW_W2);

   // the storage itself; it has no reset, only the input registers and the outputs do
   word_t mem [DEPTH];

   // per-port views, indexed by port number
   port_req_s   req      [NP];
   port_cfg_s   cfg      [NP];
   logic        out_rst  [NP];
   port_req_s   req_q    [NP];
   port_req_s   req_d    [NP];
   logic        rd_ok    [NP];
   logic        wr_ok    [NP];
   logic        do_wr    [NP];
   logic        do_rd    [NP];
   logic        load     [NP];
   word_t       rd_word  [NP];
   word_t       load_dat [NP];
   write_mode_e eff_mode [NP];
   word_t       dout_w   [NP];
   logic        vld_w    [NP];
   word_t       data_mask;

   // fold the named ports into arrays for the per-port loop
   assign req[`EBR_PORT_A]     = req_a;
   assign req[`EBR_PORT_B]     = req_b;
   assign cfg[`EBR_PORT_A]     = cfg_a;
   assign cfg[`EBR_PORT_B]     = cfg_b;
   assign out_rst[`EBR_PORT_A] = port_a_output_reset;
   assign out_rst[`EBR_PORT_B] = port_b_output_reset;

   // bits above the configured width are never stored
   generate
      for (genvar i = 0; i < `EBR_DATA_W; i++) begin : g_mask
         assign data_mask[i] = (i < DATA_W);
      end
   endgenerate

   generate
      for (genvar p = 0; p < NP; p++) begin : g_port

         // role of this port under the sharing mode:
         // single uses port a only, pseudo-dual writes on a and reads on b
         assign rd_ok[p] = (port_mode == pm_true_dual) ||
                           (port_mode == pm_single      && p == `EBR_PORT_A) ||
                           (port_mode == pm_pseudo_dual && p == `EBR_PORT_B);
         assign wr_ok[p] = (port_mode == pm_true_dual) ||
                           (port_mode != pm_true_dual   && p == `EBR_PORT_A);

         // request as captured; disallowed operations are dropped here
         always_comb begin
            req_d[p]      = req[p];
            req_d[p].din  = req[p].din & data_mask;
            req_d[p].we   = req[p].en & req[p].we & wr_ok[p];
            req_d[p].en   = req[p].en & (req_d[p].we | rd_ok[p]);
         end

         // input registers in front of the array, every mode
         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               req_q[p] <= '0;
            end else begin
               req_q[p] <= req_d[p];
            end
         end

         // unsupported read-before-write width behaves as normal
         assign eff_mode[p] = (cfg[p].mode == wm_read_before_write && !RBW_OK) ?
                              wm_normal : cfg[p].mode;

         assign do_wr[p]   = req_q[p].en & req_q[p].we;
         assign do_rd[p]   = req_q[p].en & ~req_q[p].we;
         // array read sees the word before this edge's write lands
         assign rd_word[p] = mem[req_q[p].addr];

         // which writes touch the output latch, and with what
         always_comb begin
            load[p]     = 1'b0;
            load_dat[p] = rd_word[p];
            if (do_rd[p]) begin
               load[p] = 1'b1;
            end else if (do_wr[p]) begin
               case (eff_mode[p])
                  wm_normal: begin
                     load[p] = 1'b0;
                  end
                  wm_write_through: begin
                     load[p]     = 1'b1;
                     load_dat[p] = req_q[p].din;
                  end
                  wm_read_before_write: begin
                     load[p]     = 1'b1;
                     load_dat[p] = rd_word[p];
                  end
                  default: begin
                     load[p] = 1'b0;
                  end
               endcase
            end
         end

         // output latch and optional register with its own clear style
         ram_out_stage #(
            .ASYNC_CLR (p == `EBR_PORT_A ? ASYNC_CLR_A : ASYNC_CLR_B)
         ) u_out (
            .clk_sys        (clk_sys),
            .rst_n          (rst_n),
            .global_reset_n (global_reset_n),
            .port_reset     (out_rst[p]),
            .out_reg        (cfg[p].out_reg),
            .load           (load[p]),
            .load_data      (load_dat[p]),
            .dout           (dout_w[p]),
            .dout_vld       (vld_w[p])
         );
      end
   endgenerate

   // array writes; on a same-address clash port a wins.
   // output resets never reach here, so the contents survive them
   always_ff @(posedge clk_sys) begin
      if (do_wr[`EBR_PORT_A]) begin
         mem[req_q[`EBR_PORT_A].addr] <= req_q[`EBR_PORT_A].din;
      end
      if (do_wr[`EBR_PORT_B] &&
          !(do_wr[`EBR_PORT_A] &&
            req_q[`EBR_PORT_A].addr == req_q[`EBR_PORT_B].addr)) begin
         mem[req_q[`EBR_PORT_B].addr] <= req_q[`EBR_PORT_B].din;
      end
   end

   // outputs come straight from the output flops of each stage
   assign dout_a     = dout_w[`EBR_PORT_A];
   assign dout_vld_a = vld_w[`EBR_PORT_A];
   assign dout_b     = dout_w[`EBR_PORT_B];
   assign dout_vld_b = vld_w[`EBR_PORT_B];

endmodule

/* File: sim/ebr_asserts.sv */
module ebr_checker
   import ebr_pkg::*;
#(
   parameter bit ASYNC_CLR_A = 1'b0,
   parameter bit ASYNC_CLR_B = 1'b0
) (
   // clock and resets
   input wire logic       clk_sys,
   input wire logic       rst_n,
   input wire logic       global_reset_n,
   input wire logic       port_a_output_reset,
   input wire logic       port_b_output_reset,
   // configuration and requests
   input wire port_mode_e port_mode,
   input wire port_cfg_s  cfg_a,
   input wire port_cfg_s  cfg_b,
   input wire port_req_s  req_a,
   input wire port_req_s  req_b,
   // read data
   input wire word_t      dout_a,
   input wire logic       dout_vld_a,
   input wire word_t      dout_b,
   input wire logic       dout_vld_b
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // request kinds; a clear in flight would legally drop the answer
   wire calm = global_reset_n && !port_a_output_reset && !port_b_output_reset;
   wire a_wr = req_a.en && req_a.we;
   wire a_rd = req_a.en && !req_a.we && port_mode != pm_pseudo_dual;
   wire b_rd = req_b.en && !req_b.we && port_mode != pm_single;

   // request taken, then no clear up to the answer
   sequence s_take3(go);
      go ##0 calm [*3];
   endsequence
   sequence s_take4(go);
      go ##0 calm [*4];
   endsequence

   AST_WT_ECHO: assert property (s_take3(a_wr && cfg_a.mode == wm_write_through && !cfg_a.out_reg) |->
      dout_vld_a && dout_a == $past(req_a.din, 2)) else $error("write-through echo wrong");
   AST_NORMAL_HIDE: assert property (s_take3(a_wr && cfg_a.mode == wm_normal && !cfg_a.out_reg) |->
      !dout_vld_a) else $error("normal write shown");
   AST_RBW_SHOWS: assert property (s_take3(a_wr && cfg_a.mode == wm_read_before_write && !cfg_a.out_reg) |->
      dout_vld_a) else $error("read-before-write gave no word");
   AST_RD_BYPASS: assert property (s_take3(a_rd && !cfg_a.out_reg) |-> dout_vld_a)
      else $error("bypassed read late");
   AST_RD_REG: assert property (s_take4(b_rd && cfg_b.out_reg) |-> dout_vld_b)
      else $error("registered read late");
   AST_A_CLR_ONLY: assert property (port_a_output_reset && !port_b_output_reset && !ASYNC_CLR_A
      |=> dout_a == '0 && !dout_vld_a && (dout_vld_b || $stable(dout_b)))
      else $error("port a clear wrong");
   AST_B_CLR_SYNC: assert property (port_b_output_reset && !ASYNC_CLR_B |=>
      dout_b == '0 && !dout_vld_b) else $error("port b clear wrong");
   AST_GLB_CLR: assert property (!global_reset_n |=> dout_a == '0 && dout_b == '0)
      else $error("global clear wrong");
endmodule

bind embedded_block_ram ebr_checker #(.ASYNC_CLR_A(ASYNC_CLR_A), .ASYNC_CLR_B(ASYNC_CLR_B)) chk (
   .clk_sys(clk_sys), .rst_n(rst_n), .global_reset_n(global_reset_n),
   .port_a_output_reset(port_a_output_reset), .port_b_output_reset(port_b_output_reset),
   .port_mode(port_mode), .cfg_a(cfg_a), .cfg_b(cfg_b), .req_a(req_a), .req_b(req_b),
   .dout_a(dout_a), .dout_vld_a(dout_vld_a), .dout_b(dout_b), .dout_vld_b(dout_vld_b));

/* File: sim/fabric_model.sv */
module fabric_model
   import ebr_pkg::*;
(
   // clock
   input  wire logic clk_sys,
   // requests towards the ram
   output port_req_s req_a,
   output port_req_s req_b
);
   timeunit 1ns;
   timeprecision 1ns;

   // both ports idle from time zero
   initial begin
      req_a = '0;
      req_b = '0;
   end

   // one request, held through its capturing edge; the other port drops
   task automatic issue(input bit pb, input bit we, input addr_t a, input word_t d);
      port_req_s r;
      r = '{en: 1'b1, we: we, addr: a, din: d};
      if (pb) begin
         req_b = r;
         req_a.en = 1'b0;
      end else begin
         req_a = r;
         req_b.en = 1'b0;
      end
      @(posedge clk_sys); // captured at this edge
      #1;
   endtask

   // released lines flip so stale values never look valid
   task automatic idle();
      req_a = '{1'b0, 1'b0, ~req_a.addr, ~req_a.din};
      req_b = '{1'b0, 1'b0, ~req_b.addr, ~req_b.din};
   endtask
endmodule

/* File: sim/tb_top.sv */
module tb_top
   import ebr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk_sys = 1'b0;
   logic       rst_n = 1'b0;
   logic       global_reset_n = 1'b1;
   logic       port_a_output_reset = 1'b0;
   logic       port_b_output_reset = 1'b0;
   port_mode_e port_mode = pm_true_dual;
   port_cfg_s  cfg_a = '{wm_write_through, 1'b0};
   port_cfg_s  cfg_b = '{wm_normal, 1'b1};
   port_req_s  req_a, req_b;
   word_t      dout_a, dout_b;
   logic       dout_vld_a, dout_vld_b;
   word_t      mem [addr_t];
   word_t      qa [$], qb [$];
   addr_t      ad [6];
   int         err_count = 0;
   int         samples_checked = 0;

   always #20 clk_sys = ~clk_sys;

   embedded_block_ram #(.DATA_W(36), .ASYNC_CLR_A(1'b0), .ASYNC_CLR_B(1'b0)) DUT (
      .clk_sys(clk_sys), .rst_n(rst_n), .global_reset_n(global_reset_n),
      .port_a_output_reset(port_a_output_reset), .port_b_output_reset(port_b_output_reset),
      .port_mode(port_mode), .cfg_a(cfg_a), .cfg_b(cfg_b), .req_a(req_a), .req_b(req_b),
      .dout_a(dout_a), .dout_vld_a(dout_vld_a), .dout_b(dout_b), .dout_vld_b(dout_vld_b));
   fabric_model fab (.clk_sys(clk_sys), .req_a(req_a), .req_b(req_b));

   task automatic check(input string nm, input word_t got, input word_t exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // note the expected word by write mode, then hand the request over
   task automatic acc(input bit pb, input bit we, input addr_t a, input word_t d);
      write_mode_e m;
      word_t       e;
      m = pb ? cfg_b.mode : cfg_a.mode;
      e = !we ? mem[a] : (m == wm_write_through ? d : mem[a]);
      if (!we || m != wm_normal) begin
         if (pb) qb.push_back(e);
         else qa.push_back(e);
      end
      if (we) mem[a] = d;
      fab.issue(pb, we, a, d);
   endtask

   // bounded wait for every noted answer, plus the longest latency
   task automatic drain();
      fab.idle();
      for (int i = 0; i < 20 && qa.size() + qb.size() > 0; i++) @(posedge clk_sys);
      repeat (3) @(posedge clk_sys);
      #1;
      if (qa.size() + qb.size() > 0) begin
         err_count++;
         $display("[ERR] answers missing");
         report_and_stop();
      end
   endtask

   // one-cycle pulse on a level reset input
   task automatic pulse(ref logic s, input logic act);
      s = act;
      @(posedge clk_sys);
      #1;
      s = ~act;
   endtask

   // an answer with nothing noted compares against its own inverse
   always @(posedge clk_sys) begin
      if (dout_vld_a === 1'b1) check("dout_a", dout_a, qa.size() ? qa.pop_front() : ~dout_a);
      if (dout_vld_b === 1'b1) check("dout_b", dout_b, qb.size() ? qb.pop_front() : ~dout_b);
   end

   initial begin
      void'($urandom(32'hfd96));
      repeat (10) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      @(posedge clk_sys);
      #1;
      // back-to-back writes echoed on a, read back on registered b
      for (int i = 0; i < 6; i++) begin
         ad[i] = addr_t'($urandom_range(511, 16));
         acc(1'b0, 1'b1, ad[i], word_t'({$urandom, $urandom}));
      end
      for (int i = 0; i < 6; i++) acc(1'b1, 1'b0, ad[i], '0);
      drain();
      acc(1'b1, 1'b1, 9'h007, 36'h5_a5a5_a5a5); // normal write hidden
      acc(1'b0, 1'b0, 9'h007, '0);
      drain();
      cfg_a.mode = wm_read_before_write;
      acc(1'b0, 1'b1, 9'h007, 36'hc_3c3c_3c3c); // old word shown
      acc(1'b0, 1'b0, 9'h007, '0);
      drain();
      cfg_a.mode = wm_normal;
      acc(1'b0, 1'b1, 9'h009, 36'h1_2345_6789);
      acc(1'b0, 1'b0, 9'h009, '0);
      drain();
      pulse(port_a_output_reset, 1'b1);
      check("dout_a", dout_a, '0);
      check("dout_b", dout_b, mem[ad[5]]);
      acc(1'b0, 1'b0, 9'h009, '0); // array survives the clear
      drain();
      pulse(port_b_output_reset, 1'b1);
      check("dout_b", dout_b, '0);
      check("dout_a", dout_a, mem[9'h009]);
      acc(1'b1, 1'b0, 9'h007, '0);
      drain();
      pulse(global_reset_n, 1'b0);
      check("dout_a", dout_a, '0);
      check("dout_b", dout_b, '0);
      port_mode = pm_pseudo_dual;
      acc(1'b0, 1'b1, 9'h003, word_t'({$urandom, $urandom}));
      drain();
      acc(1'b1, 1'b0, 9'h003, '0);
      drain();
      report_and_stop();
   end
endmodule
